// ===== core/dpsm_pkg.sv
// Constants shared by the drive power state machine files.
package dpsm_pkg;

  // ********************************************************
  // Register byte offsets
  // ********************************************************
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_MREQ = 8'h08;
  localparam logic [7:0] A_MACT = 8'h0c;
  localparam logic [7:0] A_SUBM = 8'h10;
  localparam logic [7:0] A_OPT = 8'h14;
  localparam logic [7:0] A_ERR = 8'h18;
  localparam logic [7:0] A_SPD = 8'h1c;
  localparam logic [7:0] A_THR = 8'h20;

  // ********************************************************
  // Field positions
  // ********************************************************
  localparam int CW_SO = 0;
  localparam int CW_EV = 1;
  localparam int CW_QS = 2;
  localparam int CW_EO = 3;
  localparam int CW_FR = 7;
  localparam int CW_HALT = 8;
  localparam int SUB_CL = 0;
  localparam int SUB_SLOW = 7;
  localparam int OPT_QS = 0;
  localparam int OPT_SHUT = 4;
  localparam int OPT_DISOP = 8;
  localparam int OPT_HALT = 12;
  localparam int OPT_FLT = 16;

  // ********************************************************
  // Reset values
  // ********************************************************
  localparam logic [15:0] CW_RST = 16'h0000;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [15:0] SUB_RST = 16'h0000;
  localparam logic [15:0] SUB_WMASK = 16'h0081;
  localparam logic [19:0] OPT_RST = 20'h21112;
  localparam logic [15:0] THR_RST = 16'h0010;

  // ********************************************************
  // Status codes, bits 6..0 of the status word
  // ********************************************************
  localparam logic [6:0] SW_NRDY = 7'h00;
  localparam logic [6:0] SW_SOD = 7'h40;
  localparam logic [6:0] SW_RDY = 7'h21;
  localparam logic [6:0] SW_SON = 7'h23;
  localparam logic [6:0] SW_OPEN = 7'h27;
  localparam logic [6:0] SW_QSA = 7'h07;
  localparam logic [6:0] SW_FRA = 7'h0f;
  localparam logic [6:0] SW_FLT = 7'h08;

  // ********************************************************
  // Reaction codes and ramp requests
  // ********************************************************
  localparam logic [3:0] OC_SLOW = 4'h1;
  localparam logic [3:0] OC_QUICK = 4'h2;
  localparam logic [3:0] OC_SLOW_STAY = 4'h5;
  localparam logic [3:0] OC_QUICK_STAY = 4'h6;
  localparam logic [1:0] RAMP_NONE = 2'h0;
  localparam logic [1:0] RAMP_SLOW = 2'h1;
  localparam logic [1:0] RAMP_QUICK = 2'h2;
  localparam logic [7:0] HALT_MODES = 8'h9e;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int CTRL_CYCLE_NS = 1000000;
  localparam int CYCLE_CLKS = CTRL_CYCLE_NS / CLK_PERIOD_NS;
  localparam int LPF_SHIFT = 3;
  localparam int HYST_DIV = 10;

endpackage

// ===== core/dpsm_spd_if.sv
// Link between the state machine and the speed estimator.
`timescale 1ns/1ps
interface dpsm_spd_if;
  logic tick;
  logic [15:0] enc_pos;
  logic [15:0] thr;
  logic slow_en;
  logic [15:0] speed;
  logic slow_act;
  logic standstill;
  modport ctrl(output tick, enc_pos, thr, slow_en, input speed, slow_act, standstill);
  modport est(input tick, enc_pos, thr, slow_en, output speed, slow_act, standstill);
endinterface

// ===== core/dpsm_speed.sv
// Speed estimator and slow-speed changeover of the drive.
`timescale 1ns/1ps
module dpsm_speed (
  // Clock, reset and freeze
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // Link to the state machine
  dpsm_spd_if.est s
);

  logic [15:0] prev_pos;
  logic primed;
  logic [15:0] delta;
  logic [15:0] mag;
  logic signed [17:0] diff;
  logic [16:0] thr_hi;

  // Position change per control cycle; the cycle is fixed, so the change is the speed.
  assign delta = s.enc_pos - prev_pos;
  assign mag = delta[15] ? (~delta + 16'h0001) : delta;
  assign diff = $signed({2'b00, mag}) - $signed({2'b00, s.speed});
  assign thr_hi = {1'b0, s.thr} + 17'(s.thr / 16'(dpsm_pkg::HYST_DIV));

  // Low-pass filter; the first cycle only primes the old position to avoid a spike.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prev_pos <= 16'h0000;
      primed <= 1'b0;
      s.speed <= 16'h0000;
      s.standstill <= 1'b1;
    end else if (ce && s.tick) begin
      prev_pos <= s.enc_pos;
      primed <= 1'b1;
      if (primed) begin
        s.speed <= s.speed + 16'(diff >>> dpsm_pkg::LPF_SHIFT);
        s.standstill <= (mag == 16'h0000) && (s.speed == 16'h0000);
      end
    end
  end

  // Changeover with hysteresis; standstill always falls back to closed loop.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s.slow_act <= 1'b0;
    end else if (ce && s.tick) begin
      if (!s.slow_en || s.standstill) begin
        s.slow_act <= 1'b0;
      end else if (s.slow_act && ({1'b0, s.speed} > thr_hi)) begin
        s.slow_act <= 1'b0;
      end else if (!s.slow_act && (s.speed < s.thr)) begin
        s.slow_act <= 1'b1;
      end
    end
  end

endmodule

// ===== core/dpsm_top.sv
// Power state machine of the drive with its register file on AHB-Lite.
//
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
// Operation
// - Closed loop needs submode bit 0, auto-set.
// - Slow speed needs closed loop and bit 7.
// - Changeover at threshold with 10% hysteresis.
// - Standstill forces closed-loop operation.
// - Slow speed: constant current, vector control when needed.
// - Speed is filtered position change per cycle.
// - Commands via control word, state via status word.
// - Decode shutdown, switch on, enable operation.
// - Decode disable voltage and quick stop.
// - Quick stop resume needs rising edge.
// - Fault reset only on rising edge.
// - Status codes for not ready, disabled, faults.
// - Status codes for ready, on, enabled, quick stop.
// - Passed self test enters switch on disabled.
// - Unrecoverable error locks in not ready.
// - Mode request stored, mode in force shown.
// - Exit from enabled applies the shutdown or disable operation option.
// - Quick stop option selects stop and follow-up.
// - Halt bit brakes with the halt option.
// - Fault reaction brakes per code, error recorded.
module dpsm_top #(
  parameter int CYCLE_CLKS = dpsm_pkg::CYCLE_CLKS
) (
  // Clock, reset and freeze
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Drive events
  input wire logic self_test_ok,
  input wire logic fault_event,
  input wire logic [15:0] fault_code,
  input wire logic unrecoverable,
  input wire logic autosetup_done,
  input wire logic ramp_done,
  input wire logic follow_err,
  input wire logic [15:0] enc_pos,
  // Drive control
  output logic power_on,
  output logic [1:0] ramp_sel,
  output logic halt_active,
  output logic closed_loop_en,
  output logic slow_speed_active,
  output logic vector_ctrl
);

  typedef enum logic [2:0] {
    ST_NRDY, ST_SOD, ST_RDY, ST_SON, ST_OPEN, ST_QSA, ST_FRA, ST_FLT
  } dpsm_state_e;
  typedef enum logic [2:0] {
    CMD_NONE, CMD_SHUT, CMD_SWON, CMD_DISV, CMD_QS, CMD_ENA
  } dpsm_cmd_e;

  dpsm_state_e state;
  dpsm_state_e next_state;
  dpsm_cmd_e cmd;
  logic [1:0] next_ramp;
  logic [15:0] cw;
  logic [15:0] cw_prev;
  logic [6:0] stat;
  logic [7:0] mode_req;
  logic [7:0] mode_act;
  logic [15:0] subm;
  logic [19:0] opt;
  logic [15:0] thr;
  logic [15:0] err_code;
  logic dead;
  logic [31:0] cyc_cnt;
  logic dp_wr;
  logic [7:0] dp_addr;
  logic rd_wait;
  logic ap;
  logic wr;
  logic fr_rise;
  logic qs_resume;
  logic qs_stay;
  logic halt_req;
  logic [3:0] qs_opt;

  dpsm_spd_if spd();

  // ********************************************************
  // Decoding helpers
  // ********************************************************

  // Control word to command; bit 7 set is the fault reset and matches no move here.
  function automatic dpsm_cmd_e cmd_decode(input logic [15:0] w);
    if (w[dpsm_pkg::CW_FR]) begin
      return CMD_NONE;
    end else if (!w[dpsm_pkg::CW_EV]) begin
      return CMD_DISV;
    end else if (!w[dpsm_pkg::CW_QS]) begin
      return CMD_QS;
    end else if (!w[dpsm_pkg::CW_SO]) begin
      return CMD_SHUT;
    end else if (!w[dpsm_pkg::CW_EO]) begin
      return CMD_SWON;
    end
    return CMD_ENA;
  endfunction

  // Reaction code to ramp request; codes without a ramp switch the driver off, except for a halt, which keeps it on.
  function automatic logic [1:0] ramp_for(input logic [3:0] c);
    if (c == dpsm_pkg::OC_SLOW || c == dpsm_pkg::OC_SLOW_STAY) begin
      return dpsm_pkg::RAMP_SLOW;
    end else if (c == dpsm_pkg::OC_QUICK || c == dpsm_pkg::OC_QUICK_STAY) begin
      return dpsm_pkg::RAMP_QUICK;
    end
    return dpsm_pkg::RAMP_NONE;
  endfunction

  // State to status code.
  function automatic logic [6:0] sw_of(input dpsm_state_e s);
    case (s)
      ST_NRDY: return dpsm_pkg::SW_NRDY;
      ST_SOD: return dpsm_pkg::SW_SOD;
      ST_RDY: return dpsm_pkg::SW_RDY;
      ST_SON: return dpsm_pkg::SW_SON;
      ST_OPEN: return dpsm_pkg::SW_OPEN;
      ST_QSA: return dpsm_pkg::SW_QSA;
      ST_FRA: return dpsm_pkg::SW_FRA;
      default: return dpsm_pkg::SW_FLT;
    endcase
  endfunction

  // Read multiplexer; unmapped words read as zero.
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    case (a)
      dpsm_pkg::A_CTRL: return {16'h0000, cw};
      dpsm_pkg::A_STAT: return {25'h0000000, stat};
      dpsm_pkg::A_MREQ: return {24'h000000, mode_req};
      dpsm_pkg::A_MACT: return {24'h000000, mode_act};
      dpsm_pkg::A_SUBM: return {16'h0000, subm};
      dpsm_pkg::A_OPT: return {12'h000, opt};
      dpsm_pkg::A_ERR: return {16'h0000, err_code};
      dpsm_pkg::A_SPD: return {15'h0000, spd.slow_act, spd.speed};
      dpsm_pkg::A_THR: return {16'h0000, thr};
      default: return 32'h00000000;
    endcase
  endfunction

  // ********************************************************
  // AHB-Lite slave
  // ********************************************************

  assign ap = hsel && htrans[1] && hready;
  assign wr = ce && dp_wr;

  // Zero-wait reads, except a read right behind a write, which waits one cycle
  // so that it returns the value just written rather than the stale one.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dp_wr <= 1'b0;
      dp_addr <= 8'h00;
      rd_wait <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
    end else if (ce) begin
      dp_wr <= ap && hwrite;
      if (ap) begin
        dp_addr <= haddr[7:0];
      end
      if (ap && !hwrite) begin
        if (dp_wr) begin
          hreadyout <= 1'b0;
          rd_wait <= 1'b1;
        end else begin
          hrdata <= rd_mux(haddr[7:0]);
        end
      end
      if (rd_wait) begin
        hrdata <= rd_mux(dp_addr);
        hreadyout <= 1'b1;
        rd_wait <= 1'b0;
      end
    end
  end

  // Host registers; the host alone writes the command word.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cw <= dpsm_pkg::CW_RST;
      mode_req <= dpsm_pkg::MODE_RST;
      opt <= dpsm_pkg::OPT_RST;
      thr <= dpsm_pkg::THR_RST;
    end else if (wr) begin
      if (dp_addr == dpsm_pkg::A_CTRL) begin
        cw <= hwdata[15:0];
      end
      if (dp_addr == dpsm_pkg::A_MREQ) begin
        mode_req <= hwdata[7:0];
      end
      if (dp_addr == dpsm_pkg::A_OPT) begin
        opt <= hwdata[19:0];
      end
      if (dp_addr == dpsm_pkg::A_THR) begin
        thr <= hwdata[15:0];
      end
    end
  end

  // Submode select; a finished auto setup wins over a software clear.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      subm <= dpsm_pkg::SUB_RST;
    end else if (ce) begin
      if (wr && dp_addr == dpsm_pkg::A_SUBM) begin
        subm <= hwdata[15:0] & dpsm_pkg::SUB_WMASK;
      end
      if (autosetup_done) begin
        subm[dpsm_pkg::SUB_CL] <= 1'b1;
      end
    end
  end

  // ********************************************************
  // Power state machine
  // ********************************************************

  assign cmd = cmd_decode(cw);
  assign fr_rise = cw[dpsm_pkg::CW_FR] && !cw_prev[dpsm_pkg::CW_FR];
  assign qs_resume = !cw[dpsm_pkg::CW_FR] && cw[dpsm_pkg::CW_EO] && cw[dpsm_pkg::CW_EV]
    && cw[dpsm_pkg::CW_SO] && !cw_prev[dpsm_pkg::CW_EO];
  assign qs_opt = opt[dpsm_pkg::OPT_QS +: 4];
  assign qs_stay = qs_opt == dpsm_pkg::OC_SLOW_STAY || qs_opt == dpsm_pkg::OC_QUICK_STAY;
  assign halt_req = cw[dpsm_pkg::CW_HALT] && mode_act[7:3] == 5'h00
    && dpsm_pkg::HALT_MODES[mode_act[2:0]];

  // Next state and ramp; a word that fits no move from the state leaves it alone.
  always_comb begin
    next_state = state;
    next_ramp = ramp_done ? dpsm_pkg::RAMP_NONE : ramp_sel;
    case (state)
      ST_NRDY: begin
        if (self_test_ok) begin
          next_state = ST_SOD;
        end
      end
      ST_SOD: begin
        if (cmd == CMD_SHUT) begin
          next_state = ST_RDY;
        end
      end
      ST_RDY: begin
        if (cmd == CMD_SWON) begin
          next_state = ST_SON;
        end else if (cmd == CMD_DISV || cmd == CMD_QS) begin
          next_state = ST_SOD;
        end
      end
      ST_SON: begin
        if (cmd == CMD_ENA) begin
          next_state = ST_OPEN;
        end else if (cmd == CMD_SHUT) begin
          next_state = ST_RDY;
        end else if (cmd == CMD_DISV || cmd == CMD_QS) begin
          next_state = ST_SOD;
        end
      end
      ST_OPEN: begin
        if (cmd == CMD_SWON) begin
          next_state = ST_SON;
          next_ramp = ramp_for(opt[dpsm_pkg::OPT_DISOP +: 4]);
        end else if (cmd == CMD_SHUT) begin
          next_state = ST_RDY;
          next_ramp = ramp_for(opt[dpsm_pkg::OPT_SHUT +: 4]);
        end else if (cmd == CMD_DISV) begin
          next_state = ST_SOD;
          next_ramp = dpsm_pkg::RAMP_NONE;
        end else if (cmd == CMD_QS) begin
          next_state = ST_QSA;
          next_ramp = ramp_for(qs_opt);
        end else if (halt_req) begin
          next_ramp = ramp_for(opt[dpsm_pkg::OPT_HALT +: 4]);
        end else begin
          next_ramp = dpsm_pkg::RAMP_NONE;
        end
      end
      ST_QSA: begin
        if (cmd == CMD_DISV) begin
          next_state = ST_SOD;
          next_ramp = dpsm_pkg::RAMP_NONE;
        end else if (!qs_stay && ramp_sel == dpsm_pkg::RAMP_NONE) begin
          next_state = ST_SOD;
        end else if (qs_stay && qs_resume) begin
          next_state = ST_OPEN;
        end
      end
      ST_FRA: begin
        if (ramp_sel == dpsm_pkg::RAMP_NONE) begin
          next_state = ST_FLT;
        end
      end
      ST_FLT: begin
        if (fr_rise) begin
          next_state = ST_SOD;
        end
      end
      default: begin
        next_state = ST_NRDY;
      end
    endcase
    if (fault_event && state != ST_NRDY && state != ST_FRA && state != ST_FLT) begin
      next_state = ST_FRA;
      next_ramp = ramp_for(opt[dpsm_pkg::OPT_FLT +: 4]);
    end
    if (unrecoverable || dead) begin
      next_state = ST_NRDY;
      next_ramp = dpsm_pkg::RAMP_NONE;
    end
  end

  // State, reaction outputs and the lock after an unrecoverable error.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= ST_NRDY;
      ramp_sel <= dpsm_pkg::RAMP_NONE;
      power_on <= 1'b0;
      dead <= 1'b0;
      cw_prev <= dpsm_pkg::CW_RST;
      stat <= dpsm_pkg::SW_NRDY;
    end else if (ce) begin
      state <= next_state;
      ramp_sel <= next_ramp;
      power_on <= next_state == ST_OPEN || (next_state == ST_QSA && qs_stay)
        || next_ramp != dpsm_pkg::RAMP_NONE;
      dead <= dead || unrecoverable;
      cw_prev <= cw;
      stat <= sw_of(state);
    end
  end

  // Error record, mode in force and drive control flags.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      err_code <= 16'h0000;
      mode_act <= dpsm_pkg::MODE_RST;
      halt_active <= 1'b0;
      vector_ctrl <= 1'b0;
    end else if (ce) begin
      if (next_state == ST_FRA && state != ST_FRA) begin
        err_code <= fault_code;
      end
      mode_act <= mode_req;
      halt_active <= halt_req && state == ST_OPEN;
      vector_ctrl <= subm[dpsm_pkg::SUB_CL] && (!spd.slow_act || follow_err);
    end
  end

  // ********************************************************
  // Control cycle and speed estimator
  // ********************************************************

  // Control cycle tick; the estimator divides by this fixed period implicitly.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cyc_cnt <= 32'h00000000;
      spd.tick <= 1'b0;
    end else if (ce) begin
      spd.tick <= cyc_cnt == 32'(CYCLE_CLKS - 1);
      cyc_cnt <= (cyc_cnt == 32'(CYCLE_CLKS - 1)) ? 32'h00000000 : cyc_cnt + 32'h00000001;
    end
  end

  assign spd.enc_pos = enc_pos;
  assign spd.thr = thr;
  assign spd.slow_en = subm[dpsm_pkg::SUB_CL] && subm[dpsm_pkg::SUB_SLOW];
  assign closed_loop_en = subm[dpsm_pkg::SUB_CL];
  assign slow_speed_active = spd.slow_act;

  dpsm_speed u_speed (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .s(spd)
  );

  // ********************************************************
  // Assertions
  // ********************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_nrdy_locked: assert property (dead |=> state == ST_NRDY)
    else $error("left not ready after unrecoverable error");
  chk_selftest_entry: assert property (ce && state == ST_NRDY && !dead
    && self_test_ok && !unrecoverable |=> state == ST_SOD)
    else $error("self test pass did not reach switch on disabled");
  chk_shutdown_move: assert property (ce && state == ST_SOD
    && cmd_decode(cw) == CMD_SHUT && !fault_event && !unrecoverable && !dead
    |=> state == ST_RDY)
    else $error("shutdown did not reach ready");
  chk_quick_stop: assert property (ce && state == ST_OPEN && !cw[7]
    && cw[2:1] == 2'b01 && !fault_event && !unrecoverable && !dead |=> state == ST_QSA)
    else $error("quick stop not taken");
  chk_reset_edge: assert property (ce && state == ST_FLT && !fr_rise && !unrecoverable
    && !dead |=> state == ST_FLT)
    else $error("fault left without rising reset bit");
  chk_resume_edge: assert property (state == ST_QSA && cw_prev[3] |=> state != ST_OPEN)
    else $error("quick stop resumed without rising edge");
  chk_status_open: assert property (ce && state == ST_OPEN |=> stat == 7'h27)
    else $error("wrong status code for operation enabled");
  chk_status_fault: assert property (ce && state == ST_FLT |=> stat == 7'h08)
    else $error("wrong status code for fault");
  chk_autosetup_bit: assert property (ce && autosetup_done |=> subm[0])
    else $error("auto setup did not set closed loop bit");
  chk_slow_gate: assert property (ce && spd.tick && !spd.slow_en |=> !spd.slow_act)
    else $error("slow speed active without enable");
  chk_standstill_cl: assert property (ce && spd.tick && spd.standstill |=> !spd.slow_act)
    else $error("slow speed active at standstill");
  chk_fra_done: assert property (ce && state == ST_FRA && ramp_sel == 2'h0
    && !unrecoverable && !dead |=> state == ST_FLT)
    else $error("finished fault reaction did not reach fault");
  chk_mode_follow: assert property (ce |=> mode_act == $past(mode_req))
    else $error("mode in force does not follow request");

endmodule

// ===== testbench/dpsm_motion.sv
// Motion logic model that answers the drive's ramp requests.
`timescale 1ns/1ps
module dpsm_motion (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Ramp handshake and encoder
  input wire logic [1:0] ramp_sel,
  input wire logic [7:0] step,
  output logic ramp_done,
  output logic [15:0] enc_pos
);
  int cnt = 0;
  // A ramp lasts 20 cycles, so the braking state can be seen mid-ramp.
  always @(posedge ref_clk) begin
    ramp_done <= !rst && ramp_sel != 2'h0 && cnt == 20;
    cnt <= (rst || ramp_sel == 2'h0 || cnt == 20) ? 0 : cnt + 1;
  end
  // The shaft turns by step counts a clock, so a control cycle of 8 clocks sees 8 times step.
  always @(posedge ref_clk) begin
    enc_pos <= rst ? 16'h1234 : enc_pos + {8'h00, step};
  end
endmodule

// ===== testbench/drive_power_state_machine_test.sv
// Self-checking bench of the drive power state machine.
`timescale 1ns/1ps
module drive_power_state_machine_test;
  logic ref_clk = 1'b0, rst = 1'b1, hwrite = 1'b0, dp_rd = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, fc, q[$];
  logic [1:0] htrans = '0, ramp_sel;
  logic [15:0] fault_code = '0, enc_pos;
  logic self_test_ok = 0, fault_event = 0, unrecoverable = 0, autosetup_done = 0;
  logic follow_err = 1'b0;
  logic [7:0] step = 8'h00;
  logic hreadyout, hresp, power_on, halt_active, closed_loop_en, slow_act, vector_ctrl;
  logic ramp_done;
  int failures = 0, tests_run = 0, cyc = 0;
  // Clock of 40 MHz.
  always #12.5 ref_clk = ~ref_clk;
  dpsm_top #(.CYCLE_CLKS(8)) i_dpsm_top (.ref_clk(ref_clk), .rst(rst), .ce(1'b1),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .self_test_ok(self_test_ok), .fault_event(fault_event),
    .fault_code(fault_code), .unrecoverable(unrecoverable),
    .autosetup_done(autosetup_done), .ramp_done(ramp_done), .follow_err(follow_err),
    .enc_pos(enc_pos), .power_on(power_on), .ramp_sel(ramp_sel),
    .halt_active(halt_active), .closed_loop_en(closed_loop_en),
    .slow_speed_active(slow_act), .vector_ctrl(vector_ctrl));
  dpsm_motion i_dpsm_motion (.ref_clk(ref_clk), .rst(rst), .ramp_sel(ramp_sel),
    .step(step), .ramp_done(ramp_done), .enc_pos(enc_pos));
  // ************************************************
  // Checking and closing
  // ************************************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim;
    if (failures == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Read data is compared in its data phase; the cycle ceiling cuts a hang short.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (dp_rd && hreadyout) chk("hrdata", q.pop_front(), hrdata);
    if (dp_rd && hreadyout) chk("hresp", 32'h0, {31'h0, hresp});
    if (hreadyout) dp_rd <= htrans[1] && !hwrite;
    if (cyc > 6000) begin
      failures++;
      end_sim();
    end
  end
  // ************************************************
  // Bus master and drive stimulus
  // ************************************************
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge ref_clk);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask
  // Status is read only after the word and the state have settled.
  task automatic cmd(input logic [15:0] c, input int w, input logic [6:0] s);
    bus(dpsm_pkg::A_CTRL, 1'b1, {16'h0, c});
    repeat (w) @(posedge ref_clk);
    rd(dpsm_pkg::A_STAT, {25'h0, s});
  endtask
  // One-cycle event pulse: 0 auto setup done, 1 fault, 2 unrecoverable error.
  task automatic pulse(input int k);
    autosetup_done <= (k == 0);
    fault_event <= (k == 1);
    unrecoverable <= (k == 2);
    @(posedge ref_clk);
    autosetup_done <= 1'b0;
    fault_event <= 1'b0;
    unrecoverable <= 1'b0;
  endtask
  task automatic up;
    cmd(16'h6, 30, 7'h21);
    cmd(16'h7, 30, 7'h23);
    cmd(16'hf, 30, 7'h27);
  endtask
  // New changeover threshold, then three control cycles for the changeover to act.
  task automatic thr_chk(input logic [15:0] t, input logic e);
    bus(dpsm_pkg::A_THR, 1'b1, {16'h0, t});
    repeat (24) @(posedge ref_clk);
    chk("slow_act", {31'h0, e}, {31'h0, slow_act});
  endtask
  // Main sequence.
  initial begin
    fc = $urandom(32'h85f3);
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    rd(dpsm_pkg::A_STAT, 32'h0);
    rd(dpsm_pkg::A_OPT, 32'h21112);
    rd(dpsm_pkg::A_THR, 32'h10);
    rd(dpsm_pkg::A_SUBM, 32'h0);
    rd(8'h24, 32'h0);
    fc = {24'h0, 8'($urandom)};
    bus(dpsm_pkg::A_MREQ, 1'b1, fc);
    rd(dpsm_pkg::A_MACT, fc);
    pulse(0);
    rd(dpsm_pkg::A_SUBM, 32'h1);
    chk("closed_loop_en", 32'h1, {31'h0, closed_loop_en});
    bus(dpsm_pkg::A_SUBM, 1'b1, 32'h81);
    rd(dpsm_pkg::A_SUBM, 32'h81);
    chk("slow_act", 32'h0, {31'h0, slow_act});
    chk("vector_ctrl", 32'h1, {31'h0, vector_ctrl});
    // Slow turning enters slow speed; a following error brings vector control back.
    step <= 8'h01;
    repeat (40) @(posedge ref_clk);
    chk("slow_act", 32'h1, {31'h0, slow_act});
    chk("vector_ctrl", 32'h0, {31'h0, vector_ctrl});
    follow_err <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk("vector_ctrl", 32'h1, {31'h0, vector_ctrl});
    follow_err <= 1'b0;
    // Fast turning leaves slow speed; the speed then settles at exactly 16 from above.
    step <= 8'h04;
    repeat (200) @(posedge ref_clk);
    step <= 8'h02;
    repeat (200) @(posedge ref_clk);
    chk("slow_act", 32'h0, {31'h0, slow_act});
    thr_chk(16'h11, 1'b1);
    thr_chk(16'h0f, 1'b1);
    thr_chk(16'h0e, 1'b0);
    step <= 8'h00;
    repeat (200) @(posedge ref_clk);
    chk("slow_act", 32'h0, {31'h0, slow_act});
    chk("vector_ctrl", 32'h1, {31'h0, vector_ctrl});
    self_test_ok <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd(dpsm_pkg::A_STAT, 32'h40);
    up();
    cmd(16'h6, 30, 7'h21);
    up();
    cmd(16'h7, 30, 7'h23);
    cmd(16'h0, 30, 7'h40);
    cmd(16'h6, 30, 7'h21);
    cmd(16'h0, 30, 7'h40);
    up();
    cmd(16'hb, 4, 7'h07);
    chk("ramp_sel", 32'h2, {30'h0, ramp_sel});
    repeat (30) @(posedge ref_clk);
    rd(dpsm_pkg::A_STAT, 32'h40);
    bus(dpsm_pkg::A_OPT, 1'b1, 32'h21116);
    up();
    cmd(16'hb, 30, 7'h07);
    chk("power_on", 32'h1, {31'h0, power_on});
    cmd(16'h7, 30, 7'h07);
    cmd(16'hf, 30, 7'h27);
    bus(dpsm_pkg::A_MREQ, 1'b1, 32'h1);
    bus(dpsm_pkg::A_CTRL, 1'b1, 32'h10f);
    repeat (4) @(posedge ref_clk);
    chk("halt_active", 32'h1, {31'h0, halt_active});
    fault_code <= fc[15:0] ^ 16'($urandom);
    pulse(1);
    repeat (4) @(posedge ref_clk);
    rd(dpsm_pkg::A_STAT, 32'h0f);
    chk("ramp_sel", 32'h2, {30'h0, ramp_sel});
    repeat (30) @(posedge ref_clk);
    rd(dpsm_pkg::A_STAT, 32'h08);
    rd(dpsm_pkg::A_ERR, {16'h0, fault_code});
    cmd(16'h80, 30, 7'h40);
    pulse(1);
    repeat (40) @(posedge ref_clk);
    cmd(16'h80, 30, 7'h08);
    cmd(16'h0, 30, 7'h08);
    cmd(16'h80, 30, 7'h40);
    bus(dpsm_pkg::A_STAT, 1'b1, 32'h27);
    rd(dpsm_pkg::A_STAT, 32'h40);
    pulse(2);
    cmd(16'h6, 30, 7'h00);
    cmd(16'h80, 30, 7'h00);
    repeat (4) @(posedge ref_clk);
    end_sim();
  end
endmodule
